// ==== logic/access_arbiter.v ====
// Data access arbiter: memory banks, peripheral bus and external port timing
//Contract
// - Path A beats B; DMA rank by bit
// - Memory split into parallel 16-bit banks
// - Loser waits for all its banks, no delay
// - Peripheral writes always full 32-bit words
// - Peripheral reads return words; requestor extracts
// - Peripheral serialized; CPU stall five or nine
// - DMA peripheral access every three cycles
// - External reads from 8/16-bit ROMs
// - DMA bursts one element per memory clock on synchronous memory
// - CPU external requests strictly one at time
// - Minimum burst bit keeps eight accesses
// - Chip-enable tail cycles per memory type
// - CPU stalls in third execute stage
// - Async load stall sum minus five; store six
// - Synchronous stalls wait for memory phase
// - Access behind async store stalls extra
// - DMA reads continue until FIFO fills
// - DMA element per memory clock or timing
// - Lowest DMA channel wins; aux programmable
`include "access_arb_defines.vh"

module access_arbiter (
   // Clock and reset
   input  wire                clock,
   input  wire                arst_n,
   // Configuration
   input  wire                dmaOverCpuRank,
   input  wire                minBurstArbitration,
   input  wire [1:0]          memType,
   input  wire [1:0]          romWidth,
   input  wire [3:0]          readSetup,
   input  wire [5:0]          readStrobe,
   input  wire [1:0]          readHold,
   input  wire [3:0]          writeSetup,
   input  wire [5:0]          writeStrobe,
   input  wire [1:0]          writeHold,
   input  wire [3:0]          sdramPrechargeTime,
   input  wire [3:0]          sdramRowToColumnTime,
   input  wire                sdramRowOpen,
   // CPU data path A
   input  wire                aReq,
   input  wire [1:0]          aTgt,
   input  wire [`BANKS-1:0]   aBanks,
   input  wire                aWrite,
   input  wire [1:0]          aSize,
   input  wire [`DATA_W-1:0]  aWdata,
   output wire                aDone,
   // CPU data path B
   input  wire                bReq,
   input  wire [1:0]          bTgt,
   input  wire [`BANKS-1:0]   bBanks,
   input  wire                bWrite,
   input  wire [1:0]          bSize,
   input  wire [`DATA_W-1:0]  bWdata,
   output wire                bDone,
   output wire [`DATA_W-1:0]  cpuRdata,
   // DMA channel selection
   input  wire [3:0]          dmaChanReq,
   input  wire                auxReq,
   input  wire                auxOverChannels,
   output wire [2:0]          dmaChanSel,
   // DMA element request
   input  wire                dmaReq,
   input  wire [1:0]          dmaTgt,
   input  wire [`BANKS-1:0]   dmaBanks,
   input  wire                dmaWrite,
   input  wire [1:0]          dmaSize,
   input  wire [`DATA_W-1:0]  dmaWdata,
   output wire                dmaAccept,
   output wire                dmaDone,
   // DMA read data
   output wire                dmaRdValid,
   output wire [`DATA_W-1:0]  dmaRdData,
   input  wire                dmaRdReady,
   // Peripheral bus
   output wire                periphStart,
   output wire                periphWrite,
   output wire [`DATA_W-1:0]  periphWdata,
   input  wire [`DATA_W-1:0]  periphRdata,
   // External memory port
   output wire                extStart,
   output wire                extWrite,
   output wire [`DATA_W-1:0]  extWdata,
   output wire                extCe_n,
   output wire [1:0]          extOwner,
   input  wire [`DATA_W-1:0]  extRdata
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ACC  = 2'h1;
   localparam ST_TAIL = 2'h2;

   reg               aDone_q, bDone_q, aActive_q, bActive_q, bParallel_q;
   reg               dmaAccept_q, dmaDone_q;
   reg [`DATA_W-1:0] cpuRdata_q;
   reg [2:0]         dmaChanSel_q;
   reg [`PERI_W-1:0] periCnt_q;
   reg [1:0]         periOwner_q;
   reg               periStart_q, periWrite_q;
   reg [`DATA_W-1:0] periWdata_q;
   reg [1:0]         extState_q, extOwner_q;
   reg [`CW-1:0]     extCnt_q, storeTail_q;
   reg [3:0]         burstCnt_q;
   reg               extStart_q, extWrite_q, extCe_n_q, memPhase_q;
   reg [`DATA_W-1:0] extWdata_q;
   reg [2:0]         chanSel;
   reg [`BANKS-1:0]  used;
   reg               aIntGo, bIntGo, dIntGo;
   wire              bufInReady, bufHeadValid;

   // Replicate narrow write data over all lanes; other lanes are don't-care
   function [`DATA_W-1:0] lanes;
      input [`DATA_W-1:0] d;
      input [1:0]         sz;
      begin
         if (sz == `SIZE_BYTE) begin
            lanes = {4{d[7:0]}};
         end else if (sz == `SIZE_HALF) begin
            lanes = {2{d[15:0]}};
         end else begin
            lanes = d;
         end
      end
   endfunction

   // Fixed rank: DMA first only when its rank bit is set
   function [1:0] pick;
      input a, b, d, dmaFirst;
      begin
         if (dmaFirst && d) begin
            pick = `OWN_DMA;
         end else if (a) begin
            pick = `OWN_A;
         end else if (b) begin
            pick = `OWN_B;
         end else if (d) begin
            pick = `OWN_DMA;
         end else begin
            pick = `OWN_NONE;
         end
      end
   endfunction

   // A read needs room for its word even if a push lands this cycle
   wire dmaRdPush = dmaDone_q ? 1'b0 :
                    ((periOwner_q == `OWN_DMA) && (periCnt_q == 6'h01) && !periWrite_q) ||
                    ((extOwner_q == `OWN_DMA) && (extState_q == ST_ACC) && (extCnt_q == `COST_ONE) && !extWrite_q);
   wire [`DATA_W-1:0] periRdataSel = periphRdata;
   wire [`DATA_W-1:0] pushData = (periOwner_q == `OWN_DMA && periCnt_q == 6'h01) ? periRdataSel : extRdata;
   wire dmaRoom = dmaWrite || (bufInReady && !(dmaRdPush && bufHeadValid));
   wire dmaBusy = ((periOwner_q == `OWN_DMA) && (periCnt_q > 6'h01)) ||
                  ((extOwner_q == `OWN_DMA) && (extState_q == ST_ACC) && (extCnt_q > `COST_ONE));

   // Pending requests stay visible until taken; DMA ones are hidden while busy or without room
   wire aPend = aReq && !aActive_q && !aDone_q;
   wire bPend = bReq && !bActive_q && !bDone_q;
   wire dPend = dmaReq && !dmaAccept_q && !dmaBusy && dmaRoom;
   wire aPer = aPend && (aTgt == `TGT_PERI);
   wire bPer = bPend && (bTgt == `TGT_PERI);
   wire dPer = dPend && (dmaTgt == `TGT_PERI);
   wire aExt = aPend && (aTgt == `TGT_EXT);
   wire bExt = bPend && (bTgt == `TGT_EXT);
   wire dExt = dPend && (dmaTgt == `TGT_EXT);
   wire [1:0] periWin = pick(aPer, bPer, dPer, dmaOverCpuRank);
   wire [1:0] extWin = pick(aExt, bExt, dExt, dmaOverCpuRank);

   // Bank arbitration, highest rank claims its banks first
   always @* begin
      used   = {`BANKS{1'b0}};
      dIntGo = 1'b0;
      if (dmaOverCpuRank && dPend && (dmaTgt == `TGT_INT)) begin
         dIntGo = 1'b1;
         used   = dmaBanks;
      end
      aIntGo = aPend && (aTgt == `TGT_INT) && ((aBanks & used) == {`BANKS{1'b0}});
      if (aIntGo) begin
         used = used | aBanks;
      end
      bIntGo = bPend && (bTgt == `TGT_INT) && ((bBanks & used) == {`BANKS{1'b0}});
      if (bIntGo) begin
         used = used | bBanks;
      end
      if (!dmaOverCpuRank) begin
         dIntGo = dPend && (dmaTgt == `TGT_INT) && ((dmaBanks & used) == {`BANKS{1'b0}});
      end
   end

   // Lowest channel wins unless the auxiliary channel is ranked above
   always @* begin
      chanSel = dmaChanSel_q;
      if (auxReq && auxOverChannels) begin
         chanSel = `AUX_SEL;
      end else if (dmaChanReq[0]) begin
         chanSel = 3'h0;
      end else if (dmaChanReq[1]) begin
         chanSel = 3'h1;
      end else if (dmaChanReq[2]) begin
         chanSel = 3'h2;
      end else if (dmaChanReq[3]) begin
         chanSel = 3'h3;
      end else if (auxReq) begin
         chanSel = `AUX_SEL;
      end
   end

   // Access costs from the programmed timing fields
   wire [`CW-1:0] rSum = {6'h00, readSetup} + {4'h0, readStrobe} + {8'h00, readHold};
   wire [`CW-1:0] wSum = {6'h00, writeSetup} + {4'h0, writeStrobe} + {8'h00, writeHold};
   wire [`CW-1:0] rBeat = (romWidth == `ROM_W8) ? {rSum[7:0], 2'h0} :
                          (romWidth == `ROM_W16) ? {rSum[8:0], 1'b0} : rSum;
   wire [`CW-1:0] rTail = `ASYNC_RD_TAIL_BASE - {8'h00, readHold};
   wire [`CW-1:0] wTail = (writeHold == 2'h0) ? `ASYNC_WR_TAIL_ZERO : `ASYNC_WR_TAIL_SET;
   wire [`CW-1:0] loadRaw = rBeat + rTail;
   wire [`CW-1:0] storeSpan = wSum + wTail;
   wire [`CW-1:0] rowSum = {6'h00, sdramPrechargeTime} + {6'h00, sdramRowToColumnTime};
   wire [`CW-1:0] rowGap = {rowSum[8:0], 1'b0};
   wire           cpuWr = (extWin == `OWN_A) ? aWrite : bWrite;
   wire           isSync = (memType != `MEM_ASYNC);
   reg  [`CW-1:0] cpuBase, dmaCost, ceTail;

   // CPU stall length and DMA element length
   always @* begin
      if (memType == `MEM_ASYNC) begin
         if (cpuWr) begin
            cpuBase = `ASYNC_STORE_STALL;
         end else if (loadRaw > `CPU_OVERHEAD) begin
            cpuBase = loadRaw - `CPU_OVERHEAD;
         end else begin
            cpuBase = `COST_ONE;
         end
         dmaCost = dmaWrite ? wSum : rBeat;
         ceTail  = extWrite_q ? wTail : rTail;
      end else if (memType == `MEM_SDRAM) begin
         if (sdramRowOpen) begin
            cpuBase = cpuWr ? `SDRAM_OPEN_STORE : `SDRAM_OPEN_LOAD;
         end else begin
            cpuBase = rowGap + (cpuWr ? `SDRAM_CLOSED_STORE : `SDRAM_CLOSED_LOAD);
         end
         dmaCost = `SYNC_ELEM_CYCLES;
         ceTail  = `SDRAM_TAIL;
      end else begin
         cpuBase = cpuWr ? `SBSRAM_STORE : `SBSRAM_LOAD;
         dmaCost = `SYNC_ELEM_CYCLES;
         ceTail  = `SBSRAM_TAIL;
      end
      if (dmaCost == {`CW{1'b0}}) begin
         dmaCost = `COST_ONE;
      end
   end

   // Odd memory-clock phase costs one more cycle; a prior store adds its remainder
   wire [`CW-1:0] cpuCost = cpuBase + storeTail_q + {9'h000, isSync & memPhase_q};
   wire [`CW-1:0] storeLoad = (storeSpan > `CPU_OVERHEAD) ? storeSpan - `CPU_OVERHEAD : {`CW{1'b0}};
   wire           cpuHigher = (aExt || bExt) && !dmaOverCpuRank;
   wire           mayYield = !minBurstArbitration || (burstCnt_q >= `MIN_BURST);

   // Peripheral bus: one job at a time, next may start on the finishing edge
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         periCnt_q   <= {`PERI_W{1'b0}};
         periOwner_q <= `OWN_NONE;
         periStart_q <= 1'b0;
         periWrite_q <= 1'b0;
         periWdata_q <= {`DATA_W{1'b0}};
         bParallel_q <= 1'b0;
      end else begin
         periStart_q <= 1'b0;
         if (periCnt_q > 6'h01) begin
            periCnt_q <= periCnt_q - 6'h01;
         end else begin
            periCnt_q   <= {`PERI_W{1'b0}};
            periOwner_q <= periWin;
            if (periWin != `OWN_NONE) begin
               periStart_q <= 1'b1;
            end
            if (periWin == `OWN_A) begin
               periCnt_q   <= `PERI_SINGLE;
               periWrite_q <= aWrite;
               periWdata_q <= lanes(aWdata, aSize);
               bParallel_q <= bPer;
            end else if (periWin == `OWN_B) begin
               // B issued alongside A finishes the combined nine-cycle stall
               periCnt_q   <= bParallel_q ? (`PERI_PARALLEL - `PERI_SINGLE) : `PERI_SINGLE;
               periWrite_q <= bWrite;
               periWdata_q <= lanes(bWdata, bSize);
               bParallel_q <= 1'b0;
            end else if (periWin == `OWN_DMA) begin
               periCnt_q   <= `PERI_DMA_PERIOD;
               periWrite_q <= dmaWrite;
               periWdata_q <= lanes(dmaWdata, dmaSize);
            end
         end
      end
   end

   // External port: single CPU accesses, DMA bursts, chip-enable tail
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         extState_q  <= ST_IDLE;
         extOwner_q  <= `OWN_NONE;
         extCnt_q    <= {`CW{1'b0}};
         burstCnt_q  <= 4'h0;
         extStart_q  <= 1'b0;
         extWrite_q  <= 1'b0;
         extWdata_q  <= {`DATA_W{1'b0}};
         extCe_n_q   <= 1'b1;
         storeTail_q <= {`CW{1'b0}};
         memPhase_q  <= 1'b0;
      end else begin
         memPhase_q <= ~memPhase_q;
         extStart_q <= 1'b0;
         if (storeTail_q != {`CW{1'b0}}) begin
            storeTail_q <= storeTail_q - `COST_ONE;
         end
         case (extState_q)
            ST_IDLE: begin
               extOwner_q <= extWin;
               if (extWin == `OWN_DMA) begin
                  extState_q <= ST_ACC;
                  extCnt_q   <= dmaCost;
                  extWrite_q <= dmaWrite;
                  extWdata_q <= dmaWdata;
                  extStart_q <= 1'b1;
                  extCe_n_q  <= 1'b0;
                  burstCnt_q <= 4'h1;
               end else if (extWin != `OWN_NONE) begin
                  // One CPU request in flight, stalled until its done pulse
                  extState_q <= ST_ACC;
                  extCnt_q   <= cpuCost;
                  extWrite_q <= cpuWr;
                  extWdata_q <= (extWin == `OWN_A) ? aWdata : bWdata;
                  extStart_q <= 1'b1;
                  extCe_n_q  <= 1'b0;
               end
            end
            ST_ACC: begin
               if (extCnt_q > `COST_ONE) begin
                  extCnt_q <= extCnt_q - `COST_ONE;
               end else if (extOwner_q != `OWN_DMA) begin
                  extState_q <= ST_IDLE;
                  extOwner_q <= `OWN_NONE;
                  extCe_n_q  <= 1'b1;
                  if (extWrite_q && (memType == `MEM_ASYNC)) begin
                     storeTail_q <= storeLoad;
                  end
               end else if (dExt && !(cpuHigher && mayYield)) begin
                  extCnt_q   <= dmaCost;
                  extWrite_q <= dmaWrite;
                  extWdata_q <= dmaWdata;
                  extStart_q <= 1'b1;
                  if (burstCnt_q < `MIN_BURST) begin
                     burstCnt_q <= burstCnt_q + 4'h1;
                  end
               end else if (dmaReq && (dmaTgt == `TGT_EXT) && !dmaRoom && !(cpuHigher && mayYield)) begin
                  extCnt_q <= {`CW{1'b0}};
               end else if (ceTail == {`CW{1'b0}}) begin
                  extState_q <= ST_IDLE;
                  extOwner_q <= `OWN_NONE;
                  extCe_n_q  <= 1'b1;
               end else begin
                  extState_q <= ST_TAIL;
                  extCnt_q   <= ceTail;
               end
            end
            default: begin
               if (extCnt_q > `COST_ONE) begin
                  extCnt_q <= extCnt_q - `COST_ONE;
               end else begin
                  extState_q <= ST_IDLE;
                  extOwner_q <= `OWN_NONE;
                  extCe_n_q  <= 1'b1;
               end
            end
         endcase
      end
   end

   // Accept and completion pulses, CPU read word returned whole
   wire periFin = (periCnt_q == 6'h01);
   wire extFin = (extState_q == ST_ACC) && (extCnt_q == `COST_ONE);
   wire aFin = (periFin && periOwner_q == `OWN_A) || (extFin && extOwner_q == `OWN_A);
   wire bFin = (periFin && periOwner_q == `OWN_B) || (extFin && extOwner_q == `OWN_B);
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aDone_q      <= 1'b0;
         bDone_q      <= 1'b0;
         aActive_q    <= 1'b0;
         bActive_q    <= 1'b0;
         dmaAccept_q  <= 1'b0;
         dmaDone_q    <= 1'b0;
         cpuRdata_q   <= {`DATA_W{1'b0}};
         dmaChanSel_q <= 3'h0;
      end else begin
         dmaChanSel_q <= chanSel;
         aDone_q      <= aIntGo || aFin;
         bDone_q      <= bIntGo || bFin;
         aActive_q    <= (aActive_q && !aFin) || (periWin == `OWN_A && periCnt_q <= 6'h01) ||
                         (extWin == `OWN_A && extState_q == ST_IDLE);
         bActive_q    <= (bActive_q && !bFin) || (periWin == `OWN_B && periCnt_q <= 6'h01) ||
                         (extWin == `OWN_B && extState_q == ST_IDLE);
         dmaAccept_q  <= dIntGo || (periWin == `OWN_DMA && periCnt_q <= 6'h01) ||
                         (extStart_q == 1'b0 && dExt && extWin == `OWN_DMA && extState_q == ST_IDLE) ||
                         (extState_q == ST_ACC && extOwner_q == `OWN_DMA && extCnt_q <= `COST_ONE &&
                          dExt && !(cpuHigher && mayYield));
         dmaDone_q    <= dIntGo || (periFin && periOwner_q == `OWN_DMA) ||
                         (extFin && extOwner_q == `OWN_DMA);
         if (periFin && (periOwner_q == `OWN_A || periOwner_q == `OWN_B)) begin
            cpuRdata_q <= periphRdata;
         end else if (extFin && (extOwner_q == `OWN_A || extOwner_q == `OWN_B)) begin
            cpuRdata_q <= extRdata;
         end
      end
   end

   // DMA read words wait here when the DMA stalls its drain
   two_entry_buffer #(.WIDTH(`DATA_W)) rdBuffer (
      .clock       (clock),
      .arst_n      (arst_n),
      .inValid     (dmaRdPush),
      .inData      (pushData),
      .inReady     (bufInReady),
      .headValid_q (bufHeadValid),
      .head_q      (dmaRdData),
      .outReady    (dmaRdReady)
   );

   // Outputs straight from flops
   assign aDone       = aDone_q;
   assign bDone       = bDone_q;
   assign cpuRdata    = cpuRdata_q;
   assign dmaChanSel  = dmaChanSel_q;
   assign dmaAccept   = dmaAccept_q;
   assign dmaDone     = dmaDone_q;
   assign dmaRdValid  = bufHeadValid;
   assign periphStart = periStart_q;
   assign periphWrite = periWrite_q;
   assign periphWdata = periWdata_q;
   assign extStart    = extStart_q;
   assign extWrite    = extWrite_q;
   assign extWdata    = extWdata_q;
   assign extCe_n     = extCe_n_q;
   assign extOwner    = extOwner_q;
endmodule

// ==== logic/access_arb_defines.vh ====
// Constants for the data access arbiter
`ifndef ACCESS_ARB_DEFINES_VH
`define ACCESS_ARB_DEFINES_VH
// Data and bank layout
`define DATA_W             32
`define BANKS              4
`define CW                 10
// Target resources
`define TGT_INT            2'h0
`define TGT_PERI           2'h1
`define TGT_EXT            2'h2
// Owners of a shared resource
`define OWN_NONE           2'h0
`define OWN_A              2'h1
`define OWN_B              2'h2
`define OWN_DMA            2'h3
// External memory kinds and ROM widths
`define MEM_ASYNC          2'h0
`define MEM_SDRAM          2'h1
`define MEM_SBSRAM         2'h2
`define ROM_W16            2'h1
`define ROM_W8             2'h2
// Access sizes
`define SIZE_BYTE          2'h0
`define SIZE_HALF          2'h1
// Peripheral bus job lengths in cycles
`define PERI_W             6
`define PERI_SINGLE        6'h05
`define PERI_PARALLEL      6'h09
`define PERI_DMA_PERIOD    6'h03
// Chip-enable tail cycles
`define ASYNC_RD_TAIL_BASE 10'h007
`define ASYNC_WR_TAIL_ZERO 10'h004
`define ASYNC_WR_TAIL_SET  10'h003
`define SDRAM_TAIL         10'h000
`define SBSRAM_TAIL        10'h004
// CPU stall figures
`define CPU_OVERHEAD       10'h005
`define ASYNC_STORE_STALL  10'h006
`define SDRAM_OPEN_LOAD    10'h011
`define SDRAM_OPEN_STORE   10'h007
`define SDRAM_CLOSED_LOAD  10'h019
`define SDRAM_CLOSED_STORE 10'h00F
`define SBSRAM_LOAD        10'h00F
`define SBSRAM_STORE       10'h007
`define COST_ONE           10'h001
// One memory clock is two CPU clocks
`define SYNC_ELEM_CYCLES   10'h002
// Minimum burst before hand-over
`define MIN_BURST          4'h8
// Channel select code of the auxiliary channel
`define AUX_SEL            3'h4
`endif

// ==== logic/two_entry_buffer.v ====
// Two-entry valid/ready buffer for DMA read data
`include "access_arb_defines.vh"

module two_entry_buffer #(
   parameter WIDTH = `DATA_W
) (
   // Clock and reset
   input  wire             clock,
   input  wire             arst_n,
   // Filling side
   input  wire             inValid,
   input  wire [WIDTH-1:0] inData,
   output wire             inReady,
   // Draining side
   output reg              headValid_q,
   output reg  [WIDTH-1:0] head_q,
   input  wire             outReady
);
   reg             tailValid_q;
   reg [WIDTH-1:0] tail_q;
   wire            pop;
   wire            push;

   // Full only when the second slot holds a word
   assign inReady = ~tailValid_q;
   assign pop     = headValid_q & outReady;
   assign push    = inValid & ~tailValid_q;

   // Head slot drives the output straight from a flop
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         headValid_q <= 1'b0;
         tailValid_q <= 1'b0;
         head_q      <= {WIDTH{1'b0}};
         tail_q      <= {WIDTH{1'b0}};
      end else if (pop) begin
         if (tailValid_q) begin
            head_q      <= tail_q;
            tailValid_q <= push;
            if (push) begin
               tail_q <= inData;
            end
         end else begin
            headValid_q <= push;
            if (push) begin
               head_q <= inData;
            end
         end
      end else if (push) begin
         if (headValid_q) begin
            tail_q      <= inData;
            tailValid_q <= 1'b1;
         end else begin
            head_q      <= inData;
            headValid_q <= 1'b1;
         end
      end
   end
endmodule

// ==== sim/access_arbiter_properties.sv ====
// Port-level checks on the data access arbiter
`include "access_arb_defines.vh"
module access_arbiter_properties (
   // Clock, reset and requests
   input logic       clock, arst_n, aReq, bReq, dmaReq, auxReq, auxOverChannels,
   input logic [1:0] aTgt,
   input logic [3:0] dmaChanReq,
   // Answers
   input logic       aDone, bDone, dmaAccept, periphStart, extStart, extCe_n,
   input logic [1:0] extOwner,
   input logic [2:0] dmaChanSel
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // A start can only be path A's when nobody else asks for the bus
   sequence aPeriStart; periphStart && aReq && aTgt == `TGT_PERI && !bReq && !dmaReq; endsequence
   sequence cpuExtStart; extStart && extOwner != `OWN_DMA; endsequence
   AST_PERI_SINGLE: assert property (aPeriStart |-> ##5 aDone) else $error("lone peripheral stall");
   AST_PERI_GAP: assert property (periphStart |=> !periphStart [*2]) else $error("peripheral start gap");
   AST_CPU_EXT_ONE: assert property (cpuExtStart |=> !extStart [*2]) else $error("CPU external burst");
   AST_CE_ACTIVE: assert property (extStart |-> !extCe_n) else $error("chip enable not active");
   AST_A_HELD: assert property (aDone |-> aReq) else $error("A done without request");
   AST_B_HELD: assert property (bDone |-> bReq) else $error("B done without request");
   AST_ACCEPT_GAP: assert property (dmaAccept |=> !dmaAccept) else $error("accepts back to back");
   AST_LOW_WINS: assert property (dmaChanReq[0] && !(auxReq && auxOverChannels) |=> dmaChanSel == 3'h0)
      else $error("channel zero lost");
   AST_AUX_RANK: assert property (auxReq && auxOverChannels |=> dmaChanSel == `AUX_SEL) else $error("aux lost");
endmodule
bind access_arbiter access_arbiter_properties chk (.*);

// ==== sim/far_side_model.sv ====
// Far side: peripheral register and external memory word
module far_side_model (
   input  logic        clock, arst_n, periphStart, periphWrite, extStart, extWrite,
   input  logic [31:0] periphWdata, extWdata,
   output logic [31:0] periphRdata, extRdata
);
   timeunit 1ns;
   timeprecision 100ps;
   // Whole words only; narrow reads are picked apart by the requestor
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         periphRdata <= 32'h0;
         extRdata <= 32'h0;
      end else begin
         if (periphStart && periphWrite) periphRdata <= periphWdata;
         if (extStart && extWrite) extRdata <= extWdata;
      end
   end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the data access arbiter
`include "access_arb_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0, arst_n = 0, dmaOverCpuRank = 0, minBurstArbitration = 0, sdramRowOpen = 1, aReq = 0, bReq = 0;
   logic aWrite = 0, bWrite = 0, auxReq = 0, auxOverChannels = 0, dmaReq = 0, dmaWrite = 0, dmaRdReady = 0;
   logic [1:0] memType = 0, romWidth = 0, readHold = 0, writeHold = 0, aTgt = 0, bTgt = 0, dmaTgt = 0;
   logic [1:0] aSize = 2'h2, bSize = 2'h2, dmaSize = 2'h2;
   logic [3:0] readSetup = 4'h2, writeSetup = 4'h2, sdramPrechargeTime = 4'h2, sdramRowToColumnTime = 4'h2;
   logic [3:0] aBanks = 4'h1, bBanks = 4'h2, dmaBanks = 4'h4, dmaChanReq = 0;
   logic [5:0] readStrobe = 6'h3, writeStrobe = 6'h3;
   logic [31:0] aWdata = 0, bWdata = 0, dmaWdata = 0;
   wire aDone, bDone, dmaAccept, dmaDone, dmaRdValid, periphStart, periphWrite, extStart, extWrite, extCe_n;
   wire [2:0] dmaChanSel;
   wire [1:0] extOwner;
   wire [31:0] cpuRdata, dmaRdData, periphWdata, periphRdata, extWdata, extRdata;
   int err_count = 0, n_checks = 0, n, na;
   access_arbiter uut (.*);
   far_side_model peer (.*);
   // Clock of 5 ns
   always #2.5 clock = ~clock;
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // Path A request held through the edge that samples done; n counts edges after the taking edge
   task automatic cpu_a(logic [1:0] tgt, logic wr, logic [1:0] sz, logic [31:0] d);
      aTgt = tgt; aWrite = wr; aSize = sz; aWdata = d; aReq = 1; n = -1;
      do begin @(posedge clock); #1; n++; end while (aDone !== 1'b1 && n < 200);
      @(posedge clock); #1;
      aReq = 0;
      @(posedge clock); #1;
   endtask
   task test_peri;
      cpu_a(`TGT_INT, 0, 2'h2, 32'h0);
      check("internal stall", 0, n);
      cpu_a(`TGT_PERI, 1, `SIZE_BYTE, 32'h000000A5);
      cpu_a(`TGT_PERI, 0, 2'h2, 32'h0);
      check("peripheral stall", 5, n);
      check("peripheral word", 32'hA5A5A5A5, cpuRdata);
   endtask
   // Both paths at once: A first, B serialized behind it
   task test_parallel;
      aTgt = `TGT_PERI; bTgt = `TGT_PERI; aWrite = 0; bWrite = 0; aReq = 1; bReq = 1; n = -1; na = 0;
      while (bDone !== 1'b1 && n < 40) begin
         @(posedge clock); #1; n++;
         if (aDone === 1'b1) na = n;
         if (na > 0 && n == na + 1) aReq = 0;
      end
      @(posedge clock); #1;
      bReq = 0;
      check("A stall", 5, na);
      check("B stall", 9, n);
      @(posedge clock); #1;
   endtask
   // Async store then load behind it, which may wait out the store
   task test_ext;
      memType = `MEM_ASYNC;
      cpu_a(`TGT_EXT, 1, 2'h2, 32'h12345678);
      check("store stall", 6, n);
      cpu_a(`TGT_EXT, 0, 2'h2, 32'h0);
      check("load stall in range", 1, n >= 7 && n <= 11);
      check("load word", 32'h12345678, cpuRdata);
   endtask
   task test_chan_sel;
      for (int i = 1; i < 16; i++) begin
         dmaChanReq = 4'(i); @(posedge clock); #1;
         check("channel", i[0] ? 0 : i[1] ? 1 : i[2] ? 2 : 3, dmaChanSel);
      end
      auxReq = 1; auxOverChannels = 1; @(posedge clock); #1;
      check("aux above", `AUX_SEL, dmaChanSel);
      auxOverChannels = 0; @(posedge clock); #1;
      check("aux below", 0, dmaChanSel);
   endtask
   // Reads stall against a full buffer, then drain without loss
   task test_buffer;
      memType = `MEM_SBSRAM; dmaTgt = `TGT_EXT; dmaReq = 1; n = 0;
      repeat (20) begin @(posedge clock); #1; if (dmaAccept === 1'b1) n++; end
      dmaReq = 0; dmaRdReady = 1;
      check("accepts while full", 2, n);
      n = 0;
      repeat (6) begin
         if (dmaRdValid === 1'b1) n++;
         if (dmaRdValid === 1'b1) check("burst word", 32'h12345678, dmaRdData);
         @(posedge clock); #1;
      end
      check("words drained", 2, n);
   endtask
   task tally_and_finish;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Watchdog well past the expected run length
   initial begin
      #20000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clock);
      #1 arst_n = 1;
      test_peri();
      test_parallel();
      test_ext();
      test_chan_sel();
      test_buffer();
      tally_and_finish();
   end
endmodule
